// ---- ctlec_top.sv ----
// Transmit frame format register, transmit error counter and APB slave
`timescale 1ns/1ps
`default_nettype none
module ctlec_top #(
  parameter int ERR_STEP = ctlec_pkg::DEFAULT_ERR_STEP
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CAN_RXD,
  input wire logic BIT_SAMPLE,
  input wire logic TX_ERR_EVT,
  input wire logic TX_OK_EVT,
  output logic TX_START,
  output ctlec_pkg::ctlec_hdr_t TX_HDR,
  output logic BUS_OFF,
  output logic IRQ
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ERR_STEP < 1 || ERR_STEP > 255) begin : g_bad_step
    $error("ERR_STEP must lie in 1..255");
  end

  localparam logic [8:0] STEP9 = 9'(ERR_STEP);

  // ************************************************************
  // State
  // ************************************************************
  ctlec_pkg::ctlec_fmt_t fmt, next_fmt;
  logic [7:0] tec, next_tec;
  logic bus_off, next_bus_off;
  logic [3:0] run, next_run;
  logic [7:0] occ, next_occ;
  logic [3:0] status, next_status;
  logic [3:0] irq_en, next_irq_en;
  logic tx_start, next_tx_start;
  ctlec_pkg::ctlec_hdr_t hdr, next_hdr;
  logic irq, next_irq;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic [31:0] prdata, next_prdata;
  logic rxd_meta, rxd_sync;

  // ************************************************************
  // Combinational helpers
  // ************************************************************
  logic acc_phase;
  logic wr_take;
  logic mapped;
  logic [7:0] fmt_read;
  logic [8:0] tec_sum;
  logic [3:0] events;

  // Access phase detection and decode
  assign acc_phase = PSEL & PENABLE;
  assign wr_take = acc_phase & pready & PWRITE;
  assign mapped = (PADDR == ctlec_pkg::OFS_FRAME_FORMAT) || (PADDR == ctlec_pkg::OFS_ERROR_COUNT)
    || (PADDR == ctlec_pkg::OFS_IRQ_STATUS) || (PADDR == ctlec_pkg::OFS_IRQ_ENABLE)
    || (PADDR == ctlec_pkg::OFS_IRQ_CLEAR) || (PADDR == ctlec_pkg::OFS_TX_CONTROL);
  // Unused format bits always read zero
  assign fmt_read = {1'b0, fmt.remote_request_select, 2'b00, fmt.payload_length_code};
  assign tec_sum = {1'b0, tec} + STEP9;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_fmt = fmt;
    next_tec = tec;
    next_bus_off = bus_off;
    next_run = run;
    next_occ = occ;
    next_irq_en = irq_en;
    next_tx_start = 1'b0;
    next_hdr = hdr;
    events = 4'h0;
    next_pready = acc_phase & ~pready;
    next_pslverr = acc_phase & ~pready & ~mapped;
    next_prdata = 32'h0000_0000;
    // Read data, captured one cycle before completion
    if (acc_phase && !pready && !PWRITE) begin
      unique case (PADDR)
        ctlec_pkg::OFS_FRAME_FORMAT: begin
          next_prdata = {24'h00_0000, fmt_read};
        end
        ctlec_pkg::OFS_ERROR_COUNT: begin
          next_prdata = {24'h00_0000, tec};
        end
        ctlec_pkg::OFS_IRQ_STATUS: begin
          next_prdata = {28'h000_0000, status};
        end
        ctlec_pkg::OFS_IRQ_ENABLE: begin
          next_prdata = {28'h000_0000, irq_en};
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
    // Register writes; error count is not writable
    if (wr_take && PADDR == ctlec_pkg::OFS_FRAME_FORMAT) begin
      next_fmt.remote_request_select = PWDATA[ctlec_pkg::FMT_RRS_BIT];
      next_fmt.payload_length_code = PWDATA[ctlec_pkg::FMT_PLC_LSB +: 4];
      events[ctlec_pkg::EVT_RESERVED_CODE] = PWDATA[3] & (|PWDATA[2:0]);
    end
    if (wr_take && PADDR == ctlec_pkg::OFS_IRQ_ENABLE) begin
      next_irq_en = PWDATA[3:0];
    end
    // Send request, refused while bus-off
    if (wr_take && PADDR == ctlec_pkg::OFS_TX_CONTROL && PWDATA[ctlec_pkg::CTRL_SEND_BIT]
        && !bus_off) begin
      next_tx_start = 1'b1;
      next_hdr.remote_request = fmt.remote_request_select;
      // Reserved codes send the full eight bytes
      if (fmt.payload_length_code > ctlec_pkg::PLC_MAX_BYTES) begin
        next_hdr.byte_count = ctlec_pkg::PLC_MAX_BYTES;
      end else begin
        next_hdr.byte_count = fmt.payload_length_code;
      end
      events[ctlec_pkg::EVT_FRAME_SENT] = 1'b1;
    end
    // Error counting while active
    if (!bus_off) begin
      if (TX_ERR_EVT) begin
        if (tec_sum[8]) begin
          next_tec = 8'hFF;
          next_bus_off = 1'b1;
          events[ctlec_pkg::EVT_BUS_OFF] = 1'b1;
        end else begin
          next_tec = tec_sum[7:0];
        end
      end else if (TX_OK_EVT && tec != 8'h00) begin
        next_tec = tec - 8'h01;
      end
    end else if (BIT_SAMPLE) begin
      // Count runs of recessive bits while bus-off
      if (!rxd_sync) begin
        next_run = 4'h0;
      end else if (run == ctlec_pkg::RUN_LAST_BIT) begin
        next_run = 4'h0;
        if (occ == ctlec_pkg::OCC_LAST) begin
          next_occ = 8'h00;
          next_tec = 8'h00;
          next_bus_off = 1'b0;
          events[ctlec_pkg::EVT_RECOVERED] = 1'b1;
        end else begin
          next_occ = occ + 8'h01;
        end
      end else begin
        next_run = run + 4'h1;
      end
    end
    if (!bus_off) begin
      next_run = 4'h0;
      next_occ = 8'h00;
    end
    // Sticky status: new event wins over a clear
    next_status = status;
    if (wr_take && PADDR == ctlec_pkg::OFS_IRQ_CLEAR) begin
      next_status = status & ~PWDATA[3:0];
    end
    next_status = next_status | events;
    next_irq = |(next_status & next_irq_en);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      fmt <= '0;
      tec <= ctlec_pkg::RST_ERROR_COUNT;
      bus_off <= 1'b0;
      run <= 4'h0;
      occ <= 8'h00;
      status <= ctlec_pkg::RST_EVENTS;
      irq_en <= ctlec_pkg::RST_EVENTS;
      tx_start <= 1'b0;
      hdr <= '0;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      fmt <= next_fmt;
      tec <= next_tec;
      bus_off <= next_bus_off;
      run <= next_run;
      occ <= next_occ;
      status <= next_status;
      irq_en <= next_irq_en;
      tx_start <= next_tx_start;
      hdr <= next_hdr;
      irq <= next_irq;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      rxd_meta <= CAN_RXD;
      rxd_sync <= rxd_meta;
    end
  end

  // Outputs straight from flops
  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign TX_START = tx_start;
  assign TX_HDR = hdr;
  assign BUS_OFF = bus_off;
  assign IRQ = irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_rtr_follows_select: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    TX_START |-> TX_HDR.remote_request == $past(fmt.remote_request_select))
    else $error("Remote request differs from select bit");

  a_len_clamped: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    TX_START && $past(fmt.payload_length_code) > 4'h8 |-> TX_HDR.byte_count == 4'h8)
    else $error("Reserved length code not clamped to eight");

  a_len_direct: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    TX_START && $past(fmt.payload_length_code) <= 4'h8
    |-> TX_HDR.byte_count == $past(fmt.payload_length_code))
    else $error("Byte count differs from length code");

  a_tec_reset_zero: assert property (@(posedge REF_CLK)
    !RST_B |=> tec == 8'h00)
    else $error("Error count not zero after reset");

  a_tec_not_written: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !TX_ERR_EVT && !TX_OK_EVT && !bus_off |=> tec == $past(tec))
    else $error("Error count changed without an event");

  a_overflow_busoff: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !bus_off && TX_ERR_EVT && tec_sum[8] |=> BUS_OFF && tec == 8'hFF && status[0])
    else $error("Overflow did not force bus-off");

  a_no_send_busoff: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    bus_off |=> !TX_START)
    else $error("Frame started while bus-off");

  a_recover_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    bus_off && BIT_SAMPLE && rxd_sync && run == 4'hA && occ == 8'h7F
    |=> tec == 8'h00 && !BUS_OFF && status[1])
    else $error("Recovery did not clear error count");

  a_fmt_unused_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    acc_phase && !pready && !PWRITE && PADDR == ctlec_pkg::OFS_FRAME_FORMAT
    |=> PRDATA[31:7] == 25'h0000000 && PRDATA[5:4] == 2'b00)
    else $error("Unimplemented format bits not zero");

  a_zero_len: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    TX_START && $past(fmt.payload_length_code) == 4'h0 |-> TX_HDR.byte_count == 4'h0)
    else $error("Zero length code sent data");

  a_irq_level: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    IRQ == |(status & irq_en))
    else $error("Interrupt does not match enabled status");

  a_err_adds_step: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !bus_off && TX_ERR_EVT && int'(tec) + ERR_STEP <= 255
    |=> int'(tec) == int'($past(tec)) + ERR_STEP)
    else $error("Error event did not add the step");

  a_ok_decrements: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !bus_off && !TX_ERR_EVT && TX_OK_EVT && tec != 8'h00 |=> tec == $past(tec) - 8'h01)
    else $error("Good frame did not lower error count");

  a_busoff_count_held: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    bus_off |=> tec == 8'hFF || (tec == 8'h00 && !BUS_OFF))
    else $error("Error count moved during bus-off");

  a_unmapped_reads_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PREADY && PSLVERR |-> PRDATA == 32'h0000_0000)
    else $error("Unmapped access returned data");

  a_ready_one_cycle: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PREADY |=> !PREADY)
    else $error("Ready stood longer than one cycle");

  // Main scenarios
  c_remote_frame: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    TX_START && TX_HDR.remote_request);
  c_bus_off_entry: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(BUS_OFF));
  c_recovery: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    $fell(BUS_OFF));
  c_unmapped: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    PREADY && PSLVERR);
  c_reserved_code: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(status[ctlec_pkg::EVT_RESERVED_CODE]));

endmodule : ctlec_top
`default_nettype wire

// ---- ctlec_pkg.sv ----
// Constants, register map and carrier types of the transmit length and error count block
// Summary of operation
// - Length code up to 1000 gives byte count; 1001 to 1111 reserved.
// - Eight-bit transmit error count, read-only to software, zero after power-on.
// - Error count overflow forces bus-off; device stops taking part in traffic.
// - 128 runs of 11 recessive bits clear the error count to zero.
package ctlec_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_FRAME_FORMAT = 8'h00;
  localparam logic [7:0] OFS_ERROR_COUNT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_TX_CONTROL = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FMT_RRS_BIT = 6;
  localparam int FMT_PLC_LSB = 0;
  localparam int CTRL_SEND_BIT = 0;
  localparam int EVT_BUS_OFF = 0;
  localparam int EVT_RECOVERED = 1;
  localparam int EVT_FRAME_SENT = 2;
  localparam int EVT_RESERVED_CODE = 3;
  localparam int EVT_COUNT = 4;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0] RST_FRAME_FORMAT = 8'h00;
  localparam logic [7:0] RST_ERROR_COUNT = 8'h00;
  localparam logic [3:0] RST_EVENTS = 4'h0;
  localparam logic [3:0] PLC_MAX_BYTES = 4'h8;
  localparam logic [3:0] RUN_LAST_BIT = 4'hA;
  localparam logic [7:0] OCC_LAST = 8'h7F;
  localparam int DEFAULT_ERR_STEP = 8;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic remote_request;
    logic [3:0] byte_count;
  } ctlec_hdr_t;

  typedef struct packed {
    logic remote_request_select;
    logic [3:0] payload_length_code;
  } ctlec_fmt_t;

endpackage : ctlec_pkg

// ---- ctlec_bus_model.sv ----
// Model of the other bus nodes: bit timing and bus level
`timescale 1ns/1ps
`default_nettype none
module ctlec_bus_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dominant,
  output logic can_rxd,
  output logic bit_sample
);
  logic [1:0] phase;
  // Level moves at phase 3, sample three cycles later so the synchroniser has settled
  always @(posedge clk) begin
    if (!rst_b) begin
      phase <= 2'h0;
      can_rxd <= 1'b1;
      bit_sample <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      bit_sample <= (phase == 2'h2);
      if (phase == 2'h3) begin
        can_rxd <= ~dominant;
      end
    end
  end
endmodule : ctlec_bus_model
`default_nettype wire

// ---- can_tx_length_and_error_count_tb.sv ----
// Self-checking bench for the frame format and transmit error count block
`timescale 1ns/1ps
`default_nettype none
module can_tx_length_and_error_count_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic err_evt = 1'b0, ok_evt = 1'b0, dom = 1'b1;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, TX_START, BUS_OFF, IRQ, can_rxd, bit_sample;
  ctlec_pkg::ctlec_hdr_t TX_HDR;
  logic [33:0] rd_q[$];
  ctlec_pkg::ctlec_hdr_t hdr_q[$];
  logic [33:0] note;
  int errors = 0, comparisons = 0, cycles = 0, rec = 0, seed, c;
  logic [31:0] r;

  ctlec_top #(.ERR_STEP(8)) DUT (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CAN_RXD(can_rxd), .BIT_SAMPLE(bit_sample),
    .TX_ERR_EVT(err_evt), .TX_OK_EVT(ok_evt), .TX_START(TX_START), .TX_HDR(TX_HDR),
    .BUS_OFF(BUS_OFF), .IRQ(IRQ));
  ctlec_bus_model bus (.clk(clk), .rst_b(rst_b), .dominant(dom), .can_rxd(can_rxd),
    .bit_sample(bit_sample));

  // ************************************************************
  // Clock, compare and bus tasks
  // ************************************************************
  always #2 clk = ~clk;

  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk_word

  task automatic chk_hdr(input ctlec_pkg::ctlec_hdr_t e, input ctlec_pkg::ctlec_hdr_t s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("wrong value frame header expected %h seen %h", e, s);
    end
  endtask : chk_hdr

  // One APB transfer; the expected answer goes to the queue first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic er);
    rd_q.push_back({~w, er, e});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (PREADY !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int n, input logic ok);
    repeat (n) begin
      @(posedge clk);
      err_evt <= ~ok;
      ok_evt <= ok;
      @(posedge clk);
      err_evt <= 1'b0;
      ok_evt <= 1'b0;
    end
  endtask : pulse

  task automatic flag(input string n, input logic e, input logic s);
    chk_word(n, {31'h0, e}, {31'h0, s});
  endtask : flag

  // Output watcher: answers and frame starts against the oldest note
  always @(posedge clk) begin
    cycles++;
    if (psel && penable && PREADY === 1'b1) begin
      note = rd_q.pop_front();
      if (note[33]) chk_word("read data", note[31:0], PRDATA);
      flag("slave error", note[32], PSLVERR);
    end
    if (TX_START === 1'b1) begin
      if (hdr_q.size() == 0) flag("frame start", 1'b0, 1'b1);
      else chk_hdr(hdr_q.pop_front(), TX_HDR);
    end
    if (BUS_OFF === 1'b1 && bit_sample) rec <= can_rxd ? rec + 1 : 0;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 32'h1FC94620;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    apb(0, ctlec_pkg::OFS_FRAME_FORMAT, 0, 0, 0);
    apb(0, ctlec_pkg::OFS_ERROR_COUNT, 0, 0, 0);
    apb(1, ctlec_pkg::OFS_IRQ_ENABLE, 32'hF, 0, 0);
    for (c = 0; c < 16; c++) begin
      r = $random(seed);
      apb(1, ctlec_pkg::OFS_FRAME_FORMAT, {r[31:4], c[3:0]}, 0, 0);
      apb(0, ctlec_pkg::OFS_FRAME_FORMAT, 0, {25'h0, r[6], 2'h0, c[3:0]}, 0);
      hdr_q.push_back({r[6], (c > 8) ? 4'h8 : c[3:0]});
      apb(1, ctlec_pkg::OFS_TX_CONTROL, 1, 0, 0);
    end
    apb(0, ctlec_pkg::OFS_IRQ_STATUS, 0, 32'hC, 0);
    flag("irq", 1'b1, IRQ);
    apb(1, ctlec_pkg::OFS_IRQ_CLEAR, 32'hF, 0, 0);
    apb(1, ctlec_pkg::OFS_ERROR_COUNT, 32'hFF, 0, 0);
    apb(0, 8'h18, 0, 0, 1);
    apb(0, ctlec_pkg::OFS_IRQ_STATUS, 0, 0, 0);
    flag("irq", 1'b0, IRQ);
    pulse(2, 0);
    apb(0, ctlec_pkg::OFS_ERROR_COUNT, 0, 32'h10, 0);
    pulse(1, 1);
    pulse(30, 0);
    apb(0, ctlec_pkg::OFS_ERROR_COUNT, 0, 32'hFF, 0);
    flag("bus off", 1'b0, BUS_OFF);
    pulse(1, 0);
    repeat (2) @(negedge clk);
    flag("bus off", 1'b1, BUS_OFF);
    apb(1, ctlec_pkg::OFS_TX_CONTROL, 1, 0, 0);
    pulse(1, 1);
    apb(0, ctlec_pkg::OFS_ERROR_COUNT, 0, 32'hFF, 0);
    apb(0, ctlec_pkg::OFS_IRQ_STATUS, 0, 32'h1, 0);
    apb(1, ctlec_pkg::OFS_IRQ_CLEAR, 32'hF, 0, 0);
    dom <= 1'b0;
    do @(negedge clk); while (BUS_OFF !== 1'b0);
    chk_word("recessive samples", 32'd1408, rec);
    apb(0, ctlec_pkg::OFS_ERROR_COUNT, 0, 0, 0);
    apb(0, ctlec_pkg::OFS_IRQ_STATUS, 0, 32'h2, 0);
    hdr_q.push_back({r[6], 4'h8});
    apb(1, ctlec_pkg::OFS_TX_CONTROL, 1, 0, 0);
    repeat (4) @(posedge clk);
    chk_word("pending notes", 32'h0, hdr_q.size() + rd_q.size());
    finish_test();
  end
endmodule : can_tx_length_and_error_count_tb
`default_nettype wire
